// ==== src/csd_cond_eval.sv ====
// condition field evaluator against the four arithmetic flags
`default_nettype none
module csd_cond_eval
  import csd_pkg::*;
(
  input wire logic [3:0] cc_field_in,
  input wire logic [3:0] flags_in,
  output logic cond_true_out
);
  logic s;
  logic z;
  logic c;
  logic v;
  logic sxv;
  assign s = flags_in[FLAG_S];
  assign z = flags_in[FLAG_Z];
  assign c = flags_in[FLAG_C];
  assign v = flags_in[FLAG_PV];
  assign sxv = s ^ v;
  always_comb
  begin
    case (cc_field_in)
      CC_ALWAYS: cond_true_out = 1'b1;
      CC_PL: cond_true_out = ~s;
      CC_MI: cond_true_out = s;
      CC_GE: cond_true_out = ~sxv;
      CC_LT: cond_true_out = sxv;
      CC_GT: cond_true_out = ~(z | sxv);
      CC_LE: cond_true_out = z | sxv;
      CC_UGT: cond_true_out = ~c & ~z;
      CC_ULE: cond_true_out = c | z;
      CC_NC: cond_true_out = ~c;
      CC_C: cond_true_out = c;
      CC_Z: cond_true_out = z;
      CC_NZ: cond_true_out = ~z;
      CC_OV: cond_true_out = v;
      CC_NOV: cond_true_out = ~v;
      default: cond_true_out = 1'b0;          // 0000: never
    endcase
  end
endmodule : csd_cond_eval
`default_nettype wire

// ==== src/csd_decode.sv ====
// condition, bus status, register field, width, flag and cycle decode
// Functional notes
// - field 1001 true when S xor P/V is 0; 0001 when it is 1.
// - field 1010 true when Z or (S xor P/V) is 0; 0010 when 1.
// - field 1011 true when C and Z both 0; 0011 when C or Z.
// - field 1111 tests carry clear, 0111 tests carry set.
// - 0110 zero, 1110 not zero, 0100 P/V set, 1100 P/V clear.
// - field selects word n, aligned pair/quad, or high/low byte of n mod 8.
// - status codes 0-7: internal, refresh, I/O, special I/O, trap, NMI, NVI, VI.
// - status also shows memory, coprocessor, fetch kinds; one code stays reserved.
// - add-immediate first digit is 0 for word and byte, 1 for long.
// - byte and long variants use 8 and 32 bit operands, word 16.
// - each flag is cleared, set, from result, kept, or left undefined.
// - cycle count depends on addressing mode, width and segmentation mode.
`default_nettype none
module csd_decode
  import csd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] cc_field_in,
  input wire logic flag_update_in,
  input wire logic [3:0] result_flags_in,
  input wire logic [11:0] flag_effect_in,
  input wire csd_pkg::csd_bus_kind_type bus_kind_in,
  input wire logic [3:0] reg_field_in,
  input wire csd_pkg::csd_width_type width_in,
  input wire csd_pkg::csd_amode_type amode_in,
  input wire csd_pkg::csd_seg_type seg_mode_in,
  output logic [3:0] flags_out,
  output logic cond_true_out,
  output logic [3:0] bus_cycle_type_lines_out,
  output logic [3:0] reg_index_out,
  output logic high_byte_reg_out,
  output logic reg_misaligned_out,
  output logic direct_mode_out,
  output logic [6:0] operand_bits_out,
  output logic [3:0] add_imm_digit_out,
  output logic [7:0] cycles_out
);
  import csd_pkg::*;

  // ==========================================================
  // flag register
  logic [3:0] next_flags;
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++)
    begin : g_flag
      csd_effect_type eff;
      assign eff = csd_effect_type'(flag_effect_in[gi*EFFECT_BITS +: EFFECT_BITS]);
      // undefined leaves the old value in place
      assign next_flags[gi] = !flag_update_in ? flags_out[gi] :
        (eff == FE_CLEAR) ? 1'b0 :
        (eff == FE_SET) ? 1'b1 :
        (eff == FE_RESULT) ? result_flags_in[gi] : flags_out[gi];
    end
  endgenerate

  // ==========================================================
  // condition evaluation on the current flags
  logic cond_now;
  csd_cond_eval u_cond (
    .cc_field_in(cc_field_in),
    .flags_in(flags_out),
    .cond_true_out(cond_now)
  );

  // ==========================================================
  // bus status; the reserved code is never driven
  logic [3:0] next_status;
  assign next_status = (bus_kind_in == BK_RESERVED) ? 4'(BK_INTERNAL) :
    4'(bus_kind_in);

  // ==========================================================
  // register field decode
  logic [3:0] next_index;
  logic next_high;
  logic next_misaligned;
  logic next_direct;
  logic is_long;
  assign is_long = (width_in == W_LONG);
  assign next_index = (width_in == W_BYTE) ? {1'b0, reg_field_in[2:0]} :
    (width_in == W_LONG) ? {reg_field_in[3:1], 1'b0} :
    (width_in == W_QUAD) ? {reg_field_in[3:2], 2'b00} : reg_field_in;
  assign next_high = (width_in == W_BYTE) && !reg_field_in[3];
  assign next_misaligned = ((width_in == W_LONG) && reg_field_in[0]) ||
    ((width_in == W_QUAD) && (reg_field_in[1:0] != 2'b00));
  assign next_direct = (amode_in != AM_REG) && (reg_field_in == 4'h0);

  // ==========================================================
  // width variants and cycle counts
  logic [6:0] next_bits;
  logic [3:0] next_digit;
  logic [7:0] next_cycles;
  logic [1:0] seg_idx;
  assign next_bits = (width_in == W_BYTE) ? BITS_BYTE :
    (width_in == W_LONG) ? BITS_LONG :
    (width_in == W_QUAD) ? BITS_QUAD : BITS_WORD;
  assign next_digit = is_long ? ADDI_DIGIT_LONG : ADDI_DIGIT_SHORT;
  // an unused segmentation code falls back to nonsegmented timing
  assign seg_idx = (seg_mode_in == SM_SEG_SHORT || seg_mode_in == SM_SEG_LONG) ?
    2'(seg_mode_in) : 2'(SM_NONSEG);
  assign next_cycles = CYC_TABLE[is_long][amode_in][seg_idx];

  // ==========================================================
  // output registers
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      flags_out <= FLAGS_RESET;
      cond_true_out <= 1'b0;
      bus_cycle_type_lines_out <= 4'(BK_INTERNAL);
      reg_index_out <= 4'h0;
      high_byte_reg_out <= 1'b0;
      reg_misaligned_out <= 1'b0;
      direct_mode_out <= 1'b0;
      operand_bits_out <= BITS_WORD;
      add_imm_digit_out <= ADDI_DIGIT_SHORT;
      cycles_out <= 8'h00;
    end
    else
    begin
      flags_out <= next_flags;
      cond_true_out <= cond_now;
      bus_cycle_type_lines_out <= next_status;
      reg_index_out <= next_index;
      high_byte_reg_out <= next_high;
      reg_misaligned_out <= next_misaligned;
      direct_mode_out <= next_direct;
      operand_bits_out <= next_bits;
      add_imm_digit_out <= next_digit;
      cycles_out <= next_cycles;
    end
  end

  // ==========================================================
  // checks
  // flags as they stood before the previous edge
  logic [3:0] pf;
  always_ff @(posedge mclk_in)
  begin
    pf <= flags_out;
  end

  AST_ALWAYS_TRUE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_ALWAYS |-> cond_true_out)
    else $error("always-true condition evaluated false");

  AST_SIGNED_GE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_GE |->
    cond_true_out == !(pf[FLAG_S] ^ pf[FLAG_PV]))
    else $error("signed greater-or-equal wrong");

  AST_SIGNED_LE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_LE |->
    cond_true_out == (pf[FLAG_Z] | (pf[FLAG_S] ^ pf[FLAG_PV])))
    else $error("signed less-or-equal wrong");

  AST_UNSIGNED_GT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_UGT |->
    cond_true_out == (!pf[FLAG_C] && !pf[FLAG_Z]))
    else $error("unsigned greater-than wrong");

  AST_STATUS_CODE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(bus_kind_in) != BK_RESERVED |->
    bus_cycle_type_lines_out == 4'($past(bus_kind_in)))
    else $error("status code does not match cycle kind");

  AST_NO_RESERVED: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    bus_cycle_type_lines_out != 4'(BK_RESERVED))
    else $error("reserved status code driven");

  AST_BYTE_SELECT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(width_in) == W_BYTE |->
    high_byte_reg_out == !$past(reg_field_in[3]) &&
    reg_index_out == {1'b0, $past(reg_field_in[2:0])})
    else $error("byte register select wrong");

  AST_ADD_DIGIT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> add_imm_digit_out == (($past(width_in) == W_LONG) ? 4'h1 : 4'h0))
    else $error("add-immediate digit wrong");

  AST_FLAG_CLEAR: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    flag_update_in && flag_effect_in[FLAG_Z*EFFECT_BITS +: EFFECT_BITS] == 3'(FE_CLEAR)
    ##1 !flag_update_in |=> !flags_out[FLAG_Z])
    else $error("cleared zero flag not held clear");

  AST_DIRECT_ZERO: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    amode_in == AM_INDEX && reg_field_in == 4'h0 |=> direct_mode_out)
    else $error("zero base field not flagged direct");

  AST_CYCLES_LONG: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    width_in == W_LONG && amode_in == AM_DIRECT && seg_mode_in == SM_SEG_LONG
    |=> cycles_out == 8'h12)
    else $error("long direct segmented cycle count wrong");

  AST_SIGNED_GT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_GT |->
    cond_true_out == !(pf[FLAG_Z] | (pf[FLAG_S] ^ pf[FLAG_PV])))
    else $error("signed greater-than wrong");

  AST_CARRY_TESTS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_NC |->
    cond_true_out == !pf[FLAG_C])
    else $error("no-carry test wrong");

  AST_ZERO_TEST: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(cc_field_in) == CC_Z |->
    cond_true_out == pf[FLAG_Z])
    else $error("zero test wrong");

  AST_OPERAND_BITS: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(width_in) == W_LONG |->
    operand_bits_out == BITS_LONG)
    else $error("long operand width wrong");

  AST_PAIR_ALIGN: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) && $past(width_in) == W_LONG |->
    (reg_index_out == {$past(reg_field_in[3:1]), 1'b0}) &&
    (reg_misaligned_out == $past(reg_field_in[0])))
    else $error("register pair select wrong");

  AST_FLAG_SET: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    flag_update_in && flag_effect_in[FLAG_S*EFFECT_BITS +: EFFECT_BITS] == 3'(FE_SET)
    |=> flags_out[FLAG_S])
    else $error("set sign flag not set");
endmodule : csd_decode
`default_nettype wire

// ==== src/csd_pkg.sv ====
// package: encodings and tables for the condition, status and register decode block
`default_nettype none
package csd_pkg;
  // ==========================================================
  // condition field codes
  localparam logic [3:0] CC_ALWAYS = 4'h8;
  localparam logic [3:0] CC_LT = 4'h1;
  localparam logic [3:0] CC_LE = 4'h2;
  localparam logic [3:0] CC_ULE = 4'h3;
  localparam logic [3:0] CC_OV = 4'h4;
  localparam logic [3:0] CC_MI = 4'h5;
  localparam logic [3:0] CC_Z = 4'h6;
  localparam logic [3:0] CC_C = 4'h7;
  localparam logic [3:0] CC_GE = 4'h9;
  localparam logic [3:0] CC_GT = 4'ha;
  localparam logic [3:0] CC_UGT = 4'hb;
  localparam logic [3:0] CC_NOV = 4'hc;
  localparam logic [3:0] CC_PL = 4'hd;
  localparam logic [3:0] CC_NZ = 4'he;
  localparam logic [3:0] CC_NC = 4'hf;
  // ==========================================================
  // flag vector positions
  localparam int FLAG_S = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_PV = 0;
  localparam int FLAG_COUNT = 4;
  localparam int EFFECT_BITS = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  // ==========================================================
  // enumerations; bus cycle kind value is the status code
  typedef enum logic [3:0] {
    BK_INTERNAL, BK_REFRESH, BK_IO, BK_SPECIAL_IO, BK_SEG_TRAP_ACK,
    BK_NMI_ACK, BK_NVI_ACK, BK_VI_ACK, BK_DATA_MEM, BK_STACK_MEM,
    BK_COP_DATA_MEM, BK_COP_STACK_MEM, BK_PROG_NTH, BK_FETCH_FIRST,
    BK_COP_XFER, BK_RESERVED
  } csd_bus_kind_type;
  typedef enum logic [1:0] {W_BYTE, W_WORD, W_LONG, W_QUAD} csd_width_type;
  typedef enum logic [2:0] {
    FE_CLEAR, FE_SET, FE_RESULT, FE_KEEP, FE_UNDEF
  } csd_effect_type;
  typedef enum logic [1:0] {AM_REG, AM_INDIRECT, AM_DIRECT, AM_INDEX} csd_amode_type;
  typedef enum logic [1:0] {SM_NONSEG, SM_SEG_SHORT, SM_SEG_LONG} csd_seg_type;
  // ==========================================================
  // operand widths and add-immediate first digit
  localparam logic [6:0] BITS_BYTE = 7'h08;
  localparam logic [6:0] BITS_WORD = 7'h10;
  localparam logic [6:0] BITS_LONG = 7'h20;
  localparam logic [6:0] BITS_QUAD = 7'h40;
  localparam logic [3:0] ADDI_DIGIT_SHORT = 4'h0;
  localparam logic [3:0] ADDI_DIGIT_LONG = 4'h1;
  // ==========================================================
  // add cycle counts: [long][amode][segmode]
  localparam logic [7:0] CYC_TABLE [2][4][3] = '{
    '{'{8'h04, 8'h04, 8'h04}, '{8'h07, 8'h07, 8'h07},
      '{8'h09, 8'h0a, 8'h0c}, '{8'h0a, 8'h0a, 8'h0d}},
    '{'{8'h08, 8'h08, 8'h08}, '{8'h0e, 8'h0e, 8'h0e},
      '{8'h0f, 8'h10, 8'h12}, '{8'h10, 8'h10, 8'h13}}
  };
endpackage : csd_pkg
`default_nettype wire

// ==== test/csd_bus_partner.sv ====
// bus side model that decodes the status lines of each bus cycle
`default_nettype none
module csd_bus_partner
  import csd_pkg::*;
(
  input wire logic [3:0] bus_cycle_type_lines_in,
  output logic mem_req_out,
  output logic fetch_out
);
  timeunit 1ns;
  timeprecision 100ps;
  csd_bus_kind_type kind;
  assign kind = csd_bus_kind_type'(bus_cycle_type_lines_in);
  assign mem_req_out = (kind == BK_DATA_MEM) || (kind == BK_STACK_MEM)
    || (kind == BK_COP_DATA_MEM) || (kind == BK_COP_STACK_MEM);
  assign fetch_out = (kind == BK_FETCH_FIRST);
endmodule : csd_bus_partner
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the condition, status and register decode block
`default_nettype none
module tb_top;
  import csd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in, reset_n_in, flag_update_in, cond, high, mis, dir, mem_req, fetch;
  logic [3:0] cc, res, kind, field, flags, lines, idx, digit, fm;
  logic [11:0] eff;
  logic [1:0] w, am, sm;
  logic [6:0] bits;
  logic [7:0] cycles;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [7:0] CYC_EXP [24] = '{8'h04, 8'h04, 8'h04, 8'h07, 8'h07, 8'h07,
    8'h09, 8'h0a, 8'h0c, 8'h0a, 8'h0a, 8'h0d, 8'h08, 8'h08, 8'h08, 8'h0e, 8'h0e, 8'h0e,
    8'h0f, 8'h10, 8'h12, 8'h10, 8'h10, 8'h13};
  csd_decode DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cc_field_in(cc),
    .flag_update_in(flag_update_in), .result_flags_in(res), .flag_effect_in(eff),
    .bus_kind_in(csd_bus_kind_type'(kind)), .reg_field_in(field),
    .width_in(csd_width_type'(w)), .amode_in(csd_amode_type'(am)),
    .seg_mode_in(csd_seg_type'(sm)), .flags_out(flags), .cond_true_out(cond),
    .bus_cycle_type_lines_out(lines), .reg_index_out(idx), .high_byte_reg_out(high),
    .reg_misaligned_out(mis), .direct_mode_out(dir), .operand_bits_out(bits),
    .add_imm_digit_out(digit), .cycles_out(cycles));
  csd_bus_partner partner (.bus_cycle_type_lines_in(lines), .mem_req_out(mem_req),
    .fetch_out(fetch));
  // ==========================================================
  // clock, timeout and shared tasks
  initial
  begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step();
    @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : step
  function automatic logic cexp(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[3] ^ f[0];
      3'h2: r = f[2] | (f[3] ^ f[0]);
      3'h3: r = f[1] | f[2];
      3'h4: r = f[0];
      3'h5: r = f[3];
      3'h6: r = f[2];
      default: r = f[1];
    endcase
    return c[3] ? ~r : r;
  endfunction : cexp
  // ==========================================================
  // scenarios
  task automatic t_reset();
    reset_n_in = 1'b0;
    step();
    chk({flags, lines}, 8'h00);
    chk({bits, cond}, 8'h20);
    chk(cycles, 8'h00);
    reset_n_in = 1'b1;
  endtask : t_reset
  task automatic t_flag(input logic upd, input logic [11:0] e, input logic [3:0] r);
    flag_update_in = upd;
    eff = e;
    res = r;
    for (int i = 0; i < 4; i++)
      if (upd && e[3*i+:3] < 3)
        fm[i] = (e[3*i+:3] == 3'h2) ? r[i] : e[3*i];
    step();
    chk({4'h0, flags}, {4'h0, fm});
  endtask : t_flag
  task automatic t_cond();
    for (int f = 0; f < 16; f++)
    begin
      t_flag(1'b1, 12'h492, f[3:0]);
      flag_update_in = 1'b0;
      for (int c = 0; c < 16; c++)
      begin
        cc = c[3:0];
        step();
        chk({7'h0, cond}, {7'h0, cexp(c[3:0], f[3:0])});
      end
    end
  endtask : t_cond
  task automatic t_status();
    for (int k = 0; k < 16; k++)
    begin
      kind = k[3:0];
      step();
      chk({4'h0, lines}, (k == 15) ? 8'h00 : 8'(k));
      chk({6'h0, mem_req, fetch}, {6'h0, k >= 8 && k <= 11, k == 13});
    end
  endtask : t_status
  task automatic t_reg();
    for (int i = 0; i < 1024; i++)
    begin
      {w, am, sm, field} = i[9:0];
      step();
      chk({idx, high, mis, dir, 1'b0}, {(w == 0) ? {1'b0, field[2:0]} : (w == 2) ?
        (field & 4'he) : (w == 3) ? (field & 4'hc) : field, w == 0 && !field[3],
        (w == 2 && field[0]) || (w == 3 && field[1:0] != 2'h0),
        am != 0 && field == 4'h0, 1'b0});
      chk({1'b0, bits}, 8'h08 << w);
      chk({4'h0, digit}, {7'h0, w == 2});
      chk(cycles, CYC_EXP[(w == 2) * 12 + am * 3 + ((sm == 3) ? 0 : sm)]);
    end
  endtask : t_reg
  initial
  begin
    {reset_n_in, flag_update_in, cc, res, kind, field, w, am, sm} = '0;
    eff = 12'h000;
    fm = 4'h0;
    repeat (4) @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_flag(1'b1, 12'h249, 4'h0);
    t_flag(1'b1, 12'h0d4, 4'h0);
    t_flag(1'b1, 12'h412, 4'he);
    t_flag(1'b0, 12'h249, 4'h5);
    t_flag(1'b1, 12'hfff, 4'h5);
    t_reset();
    fm = 4'h0;
    t_cond();
    t_status();
    t_reg();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
